// [hw/tx_hdlc_regs.svh]
// Constants of the transmit framer and partial packet buffer
// Included by the package and by the CRC step and framer design files; guarded
`ifndef TX_HDLC_REGS_SVH
`define TX_HDLC_REGS_SVH
`define NUM_CHAN 128
`define BUF_BYTES 8192
`define BLK_BYTES 16
`define FLAG_BYTE 8'h7e
`define ABORT_BYTE 8'h7f
`define FILL_BYTE 8'hff
`define CRC16_POLY 32'h0000_8408
`define CRC32_POLY 32'hedb8_8320
`define CRC_INIT 32'hffff_ffff
`define FCS16_BYTES 3'h2
`define FCS32_BYTES 3'h4
`define BYTE_BITS 4'h8
`define STUFF_ONES 3'h5
`endif

// [hw/tx_hdlc_pkg.sv]
// Types of the transmit framer and partial packet buffer
// Assumes tx_hdlc_regs.svh is on the include path
package tx_hdlc_pkg;
`include "tx_hdlc_regs.svh"
  localparam int NBLK = `BUF_BYTES / `BLK_BYTES;
  localparam int BLK_W = $clog2(NBLK);
  localparam int OFF_W = $clog2(`BLK_BYTES);
  localparam int CNT_W = BLK_W + 1;

  typedef struct packed {
    logic active;
    logic transp;
    logic crc_en;
    logic crc32;
    logic [2:0] xfer;
    logic [CNT_W-1:0] trig;
    logic [CNT_W-1:0] start_lim;
    logic [3:0] burst;
    logic [BLK_W-1:0] first_blk;
    logic [CNT_W-1:0] chain_len;
  } chan_cfg_s;

  typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_DATA = 2'b01, PH_FCS = 2'b10} phase_e;

  typedef struct packed {
    phase_e phase;
    logic [7:0] sr;
    logic [3:0] nb;
    logic [2:0] ones;
    logic raw;
    logic dat;
    logic [31:0] crc;
    logic [2:0] fcs_left;
    logic purge;
  } fr_state_s;

  typedef enum logic [1:0] {FE_IDLE = 2'b00, FE_RUN = 2'b01, FE_DONE = 2'b10} fe_state_e;
  typedef enum logic [1:0] {WR_IDLE = 2'b00, WR_REQ = 2'b01, WR_RECV = 2'b10} wr_state_e;
endpackage

// [hw/crc_step.sv]
// One-bit step of the frame check sequence, reflected form
// Assumes the caller presets and inverts the remainder itself
`timescale 1ns/1ps
`include "tx_hdlc_regs.svh"
module crc_step (
  input wire logic [31:0] crc_i,
  input wire logic bit_i,
  input wire logic wide_i,
  output logic [31:0] crc_o
);
  logic fb;
  assign fb = crc_i[0] ^ bit_i;
  // Wide selects the 32-bit polynomial, else the 16-bit one
  assign crc_o = wide_i ? ((crc_i >> 1) ^ (fb ? `CRC32_POLY : 32'h0000_0000)) :
                 ({17'h0_0000, crc_i[15:1]} ^ (fb ? `CRC16_POLY : 32'h0000_0000)); // [R01]
endmodule // crc_step

// [hw/rr_picker.sv]
// Round-robin search over a request vector
// Assumes N is a power of two so the index wraps by itself
`timescale 1ns/1ps
module rr_picker #(
  parameter int N = 128,
  parameter int W = $clog2(N)
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] req_i,
  input wire logic adv_i,
  output logic found_o,
  output logic [W-1:0] idx_o
);
  logic [W-1:0] last_ff;
  logic [W-1:0] cand;

  // Search starts just after the last winner
  always_comb begin
    cand = last_ff;
    found_o = 1'b0;
    idx_o = last_ff;
    for (int i = 1; i <= N; i++) begin
      cand = last_ff + W'(i);
      if (!found_o && req_i[cand]) begin
        found_o = 1'b1;
        idx_o = cand;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_ff <= '0;
    end else if (adv_i && found_o) begin
      last_ff <= idx_o;
    end
  end
endmodule // rr_picker

// [hw/tx_framer_buffer_block.sv]
// Transmit HDLC framer with partial packet buffer for many channels
// Assumes the assigner, DMA side and indirect access all run on ref_clk_i
`timescale 1ns/1ps
`include "tx_hdlc_regs.svh"
// Behaviour
// R01: Optional frame check sequence, CRC-CCITT or CRC-32 per channel.
// R02: Supplied packets carry at least two payload bytes.
// R03: Normal mode adds flags and zero stuffing; transparent mode sends bytes as is.
// R04: One shared engine reads, processes and writes back a channel state per request.
// R05: Packet starts only when whole packet stored or free space below limit.
// R06: Under-run aborts the packet and the rest of it is discarded.
// R07: Indirect accesses touch the RAMs only in null cycles.
// R08: Provisioning write resets the whole channel state.
// R09: Buffer of 16-byte blocks chained by a pointer RAM into circular FIFOs.
// R10: Reader and writer start at the programmed block of the chain.
// R11: Block full flag: writer sets, reader clears, pointer write clears.
// R12: Reading a block whose flag is clear is an under-run.
// R13: Track free blocks and packet ends; request when free exceeds transfer size.
// R14: Packet-end count drops when the reader passes a packet end.
// R15: Expedite when sending, free above trigger and no packet end stored.
// R16: Round-robin over expedite flags first, then over request flags.
// R17: Writer requests, stores reply, reports blocks and packet ends, capped.
// R18: Framed bytes are produced only when the assigner asks.
// R19: DMA side serves expedited requests first, regular ones last.
// R20: DMA side prefers the high-priority packet list of a channel.
// R21: Provisioning sets free space to chain length and packet ends to zero.
module tx_framer_buffer_block
  import tx_hdlc_pkg::*;
#(
  parameter int NCH = `NUM_CHAN,
  parameter int CW = $clog2(NCH)
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic asg_req_i,
  input wire logic [CW-1:0] asg_chan_i,
  input wire logic null_cycle_i,
  output logic asg_busy_o,
  output logic asg_valid_o,
  output logic [7:0] asg_byte_o,
  output logic underrun_o,
  output logic [CW-1:0] underrun_chan_o,
  output logic dma_req_o,
  output logic dma_exp_o,
  output logic [CW-1:0] dma_chan_o,
  output logic [3:0] dma_max_o,
  input wire logic dma_gnt_i,
  input wire logic dma_valid_i,
  input wire logic [7:0] dma_byte_i,
  input wire logic dma_eop_i,
  input wire logic dma_last_i,
  input wire logic ind_chan_req_i,
  input wire logic ind_chan_wr_i,
  input wire logic [CW-1:0] ind_chan_i,
  input wire chan_cfg_s ind_cfg_i,
  input wire logic ind_blk_req_i,
  input wire logic ind_blk_wr_i,
  input wire logic [BLK_W-1:0] ind_blk_i,
  input wire logic [BLK_W-1:0] ind_next_i,
  output logic ind_busy_o,
  output logic ind_done_o,
  output chan_cfg_s ind_cfg_o,
  output logic [BLK_W-1:0] ind_next_o
);
  localparam logic [OFF_W-1:0] LAST_OFF = OFF_W'(`BLK_BYTES - 1);

  chan_cfg_s cfg_ff [NCH];
  fr_state_s fr_ff [NCH];
  logic [BLK_W-1:0] rptr_ff [NCH];
  logic [OFF_W-1:0] roff_ff [NCH];
  logic [BLK_W-1:0] wptr_ff [NCH];
  logic [OFF_W-1:0] woff_ff [NCH];
  logic [CNT_W-1:0] free_ff [NCH];
  logic [CNT_W-1:0] eop_ff [NCH];
  logic [BLK_W-1:0] next_ff [NBLK];
  logic [NBLK-1:0] full_ff;
  logic [8:0] mem_ff [NBLK*`BLK_BYTES];

  // Indirect access holding registers
  logic ind_blk_ff;
  logic ind_wr_ff;
  logic [CW-1:0] ich_ff;
  logic [BLK_W-1:0] iblk_ff;
  chan_cfg_s icfg_ff;
  logic [BLK_W-1:0] inext_ff;
  logic ind_exec;
  logic ch_prov;
  logic blk_wr;

  assign ind_exec = ind_busy_o && null_cycle_i; // [R07]
  assign ch_prov = ind_exec && !ind_blk_ff && ind_wr_ff;
  assign blk_wr = ind_exec && ind_blk_ff && ind_wr_ff;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ind_busy_o <= 1'b0;
      ind_blk_ff <= 1'b0;
      ind_wr_ff <= 1'b0;
      ich_ff <= '0;
      iblk_ff <= '0;
      icfg_ff <= '0;
      inext_ff <= '0;
    end else if (!ind_busy_o) begin
      if (ind_chan_req_i || ind_blk_req_i) begin
        ind_busy_o <= 1'b1;
        ind_blk_ff <= !ind_chan_req_i;
        ind_wr_ff <= ind_chan_req_i ? ind_chan_wr_i : ind_blk_wr_i;
        ich_ff <= ind_chan_i;
        iblk_ff <= ind_blk_i;
        icfg_ff <= ind_cfg_i;
        inext_ff <= ind_next_i;
      end
    end else if (ind_exec) begin
      ind_busy_o <= 1'b0;
    end
  end

  // Indirect read data and completion pulse
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ind_done_o <= 1'b0;
      ind_cfg_o <= '0;
      ind_next_o <= '0;
    end else begin
      ind_done_o <= ind_exec;
      if (ind_exec && !ind_blk_ff) begin
        ind_cfg_o <= cfg_ff[ich_ff];
      end
      if (ind_exec && ind_blk_ff) begin
        ind_next_o <= next_ff[iblk_ff];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        cfg_ff[c] <= '0;
      end
    end else if (ch_prov) begin
      cfg_ff[ich_ff] <= icfg_ff;
    end
  end

  // Framer engine signals
  fe_state_e fe_ff;
  logic [CW-1:0] fch_ff;
  logic [2:0] bitn_ff;
  fr_state_s w_ff;
  logic [7:0] osr_ff;
  logic kill_ff;
  fr_state_s fw;
  fr_state_s nw;
  chan_cfg_s cc;
  logic [BLK_W-1:0] rb;
  logic [OFF_W-1:0] ro;
  logic [8:0] rent;
  logic bfull;
  logic start_ok;
  logic pop_c;
  logic urun_c;
  logic obit;
  logic [31:0] crc_nx;
  logic pop;
  logic rd_blk_done;
  logic eop_dec;

  assign cc = cfg_ff[fch_ff];
  assign rb = rptr_ff[fch_ff];
  assign ro = roff_ff[fch_ff];
  assign rent = mem_ff[{rb, ro}];
  assign bfull = full_ff[rb];
  assign start_ok = (eop_ff[fch_ff] != '0) || (free_ff[fch_ff] < cc.start_lim); // [R05]
  assign pop = (fe_ff == FE_RUN) && pop_c;
  assign rd_blk_done = pop && ((ro == LAST_OFF) || rent[8]);
  assign eop_dec = pop && rent[8];

  // Byte fetch when the shift register runs dry
  always_comb begin
    fw = w_ff;
    pop_c = 1'b0;
    urun_c = 1'b0;
    if (w_ff.nb == 4'h0) begin
      fw.nb = `BYTE_BITS;
      fw.raw = 1'b1;
      fw.dat = 1'b0;
      fw.sr = `FLAG_BYTE;
      if (!cc.active) begin
        fw.sr = `FILL_BYTE;
      end else begin
        case (w_ff.phase)
          PH_IDLE: begin
            if (w_ff.purge) begin
              if (bfull) begin
                pop_c = 1'b1; // [R06]
                fw.purge = !rent[8];
              end
            end else if (cc.transp) begin
              fw.sr = `FILL_BYTE;
              if (bfull) begin
                pop_c = 1'b1;
                fw.sr = rent[7:0]; // [R03]
              end
            end else if (bfull && start_ok) begin
              fw.phase = PH_DATA; // [R03]
              fw.crc = `CRC_INIT;
            end
          end
          PH_DATA: begin
            if (bfull) begin
              pop_c = 1'b1;
              fw.sr = rent[7:0];
              fw.raw = 1'b0;
              fw.dat = 1'b1;
              if (rent[8]) begin
                fw.phase = cc.crc_en ? PH_FCS : PH_IDLE; // [R01]
                fw.fcs_left = cc.crc32 ? `FCS32_BYTES : `FCS16_BYTES;
              end
            end else begin
              urun_c = 1'b1; // [R12]
              fw.sr = `ABORT_BYTE; // [R06]
              fw.phase = PH_IDLE;
              fw.purge = 1'b1;
            end
          end
          PH_FCS: begin
            fw.sr = ~w_ff.crc[7:0]; // [R01]
            fw.raw = 1'b0;
            fw.crc = w_ff.crc >> 8;
            fw.fcs_left = w_ff.fcs_left - 3'h1;
            if (w_ff.fcs_left == 3'h1) begin
              fw.phase = PH_IDLE;
            end
          end
          default: begin
            fw.phase = PH_IDLE;
          end
        endcase
      end
    end
  end

  crc_step u_crc (
    .crc_i(fw.crc),
    .bit_i(fw.sr[0]),
    .wide_i(cc.crc32),
    .crc_o(crc_nx)
  );

  // One line bit, with a zero after five ones in data and FCS bytes
  always_comb begin
    nw = fw;
    obit = 1'b0;
    if (!fw.raw && fw.ones == `STUFF_ONES) begin
      nw.ones = 3'h0; // [R03]
    end else begin
      obit = fw.sr[0];
      nw.sr = fw.sr >> 1;
      nw.nb = fw.nb - 4'h1;
      nw.ones = (obit && !fw.raw) ? fw.ones + 3'h1 : 3'h0;
      if (fw.dat) begin
        nw.crc = crc_nx;
      end
    end
  end

  // Time-sliced engine: load state, eight bit steps, write back
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fe_ff <= FE_IDLE;
      fch_ff <= '0;
      bitn_ff <= 3'h0;
      w_ff <= '0;
      osr_ff <= 8'h00;
      kill_ff <= 1'b0;
      asg_busy_o <= 1'b0;
      asg_valid_o <= 1'b0;
      asg_byte_o <= 8'h00;
    end else begin
      asg_valid_o <= 1'b0;
      case (fe_ff)
        FE_IDLE: begin
          if (asg_req_i) begin
            fe_ff <= FE_RUN; // [R18]
            fch_ff <= asg_chan_i;
            w_ff <= fr_ff[asg_chan_i]; // [R04]
            bitn_ff <= 3'h0;
            kill_ff <= 1'b0;
            asg_busy_o <= 1'b1;
          end
        end
        FE_RUN: begin
          w_ff <= nw;
          osr_ff <= {obit, osr_ff[7:1]};
          bitn_ff <= bitn_ff + 3'h1;
          if (bitn_ff == 3'h7) begin
            fe_ff <= FE_DONE;
          end
        end
        FE_DONE: begin
          fe_ff <= FE_IDLE;
          asg_busy_o <= 1'b0;
          asg_valid_o <= 1'b1; // [R18]
          asg_byte_o <= osr_ff;
        end
        default: begin
          fe_ff <= FE_IDLE;
        end
      endcase
      if (ch_prov && ich_ff == fch_ff && fe_ff != FE_IDLE) begin
        kill_ff <= 1'b1; // [R08]
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      underrun_o <= 1'b0;
      underrun_chan_o <= '0;
    end else begin
      underrun_o <= (fe_ff == FE_RUN) && urun_c;
      if ((fe_ff == FE_RUN) && urun_c) begin
        underrun_chan_o <= fch_ff;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        fr_ff[c] <= '0;
      end
    end else begin
      if (fe_ff == FE_DONE && !kill_ff) begin
        fr_ff[fch_ff] <= w_ff; // [R04]
      end
      if (ch_prov) begin
        fr_ff[ich_ff] <= '0; // [R08]
      end
    end
  end

  // Reader position in the chain
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        rptr_ff[c] <= '0;
        roff_ff[c] <= '0;
      end
    end else begin
      if (pop) begin
        roff_ff[fch_ff] <= rd_blk_done ? '0 : ro + OFF_W'(1);
        if (rd_blk_done) begin
          rptr_ff[fch_ff] <= next_ff[rb]; // [R09]
        end
      end
      if (ch_prov) begin
        rptr_ff[ich_ff] <= icfg_ff.first_blk; // [R10]
        roff_ff[ich_ff] <= '0;
      end
    end
  end

  // Roamer flags and selection
  logic [NCH-1:0] exp_vec;
  logic [NCH-1:0] req_vec;
  logic exp_found;
  logic req_found;
  logic [CW-1:0] exp_idx;
  logic [CW-1:0] req_idx;
  logic [CW-1:0] pick;
  logic [3:0] cap;
  wr_state_e wst_ff;

  for (genvar c = 0; c < NCH; c++) begin : g_flag
    assign req_vec[c] = cfg_ff[c].active && (free_ff[c] > CNT_W'(cfg_ff[c].xfer)); // [R13]
    assign exp_vec[c] = cfg_ff[c].active && (fr_ff[c].phase != PH_IDLE) &&
                        (free_ff[c] > cfg_ff[c].trig) && (eop_ff[c] == '0); // [R15]
  end

  rr_picker #(.N(NCH), .W(CW)) u_exp_pick (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .req_i(exp_vec),
    .adv_i(wst_ff == WR_IDLE),
    .found_o(exp_found),
    .idx_o(exp_idx)
  );

  rr_picker #(.N(NCH), .W(CW)) u_req_pick (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .req_i(req_vec),
    .adv_i(wst_ff == WR_IDLE && !exp_found),
    .found_o(req_found),
    .idx_o(req_idx)
  );

  assign pick = exp_found ? exp_idx : req_idx; // [R16]
  assign cap = (free_ff[pick] < CNT_W'(cfg_ff[pick].burst)) ? free_ff[pick][3:0] : cfg_ff[pick].burst;

  // Writer
  logic [CW-1:0] wch_ff;
  logic [3:0] wmax_ff;
  logic [3:0] wblk_ff;
  logic [CNT_W-1:0] weop_ff;
  logic [BLK_W-1:0] wb;
  logic [OFF_W-1:0] wo;
  logic store;
  logic wr_blk_done;
  logic wr_rep;
  logic [3:0] rep_blk;
  logic [CNT_W-1:0] rep_eop;

  assign wb = wptr_ff[wch_ff];
  assign wo = woff_ff[wch_ff];
  assign store = (wst_ff == WR_RECV) && dma_valid_i && (wblk_ff < wmax_ff); // [R17]
  assign wr_blk_done = store && ((wo == LAST_OFF) || dma_eop_i);
  assign wr_rep = (wst_ff == WR_RECV) && dma_valid_i && dma_last_i;
  assign rep_blk = wblk_ff + {3'h0, wr_blk_done};
  assign rep_eop = weop_ff + CNT_W'(store && dma_eop_i);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wst_ff <= WR_IDLE;
      wch_ff <= '0;
      wmax_ff <= 4'h0;
      wblk_ff <= 4'h0;
      weop_ff <= '0;
      dma_req_o <= 1'b0;
      dma_exp_o <= 1'b0;
      dma_chan_o <= '0;
      dma_max_o <= 4'h0;
    end else begin
      case (wst_ff)
        WR_IDLE: begin
          if (exp_found || req_found) begin
            wst_ff <= WR_REQ; // [R17]
            wch_ff <= pick;
            wmax_ff <= cap;
            wblk_ff <= 4'h0;
            weop_ff <= '0;
            dma_req_o <= 1'b1;
            dma_exp_o <= exp_found; // [R16]
            dma_chan_o <= pick;
            dma_max_o <= cap;
          end
        end
        WR_REQ: begin
          if (dma_gnt_i) begin
            dma_req_o <= 1'b0;
            wst_ff <= WR_RECV;
          end
        end
        WR_RECV: begin
          wblk_ff <= rep_blk;
          weop_ff <= rep_eop;
          if (wr_rep) begin
            wst_ff <= WR_IDLE;
          end
        end
        default: begin
          wst_ff <= WR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        wptr_ff[c] <= '0;
        woff_ff[c] <= '0;
      end
    end else begin
      if (store) begin
        woff_ff[wch_ff] <= wr_blk_done ? '0 : wo + OFF_W'(1);
        if (wr_blk_done) begin
          wptr_ff[wch_ff] <= next_ff[wb]; // [R09]
        end
      end
      if (ch_prov) begin
        wptr_ff[ich_ff] <= icfg_ff.first_blk; // [R10]
        woff_ff[ich_ff] <= '0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (store) begin
      mem_ff[{wb, wo}] <= {dma_eop_i, dma_byte_i};
    end
  end

  // Block chain and full flags
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      full_ff <= '0;
      for (int b = 0; b < NBLK; b++) begin
        next_ff[b] <= '0;
      end
    end else begin
      if (blk_wr) begin
        next_ff[iblk_ff] <= inext_ff; // [R09]
        full_ff[iblk_ff] <= 1'b0; // [R11]
      end
      if (rd_blk_done) begin
        full_ff[rb] <= 1'b0; // [R11]
      end
      if (wr_blk_done) begin
        full_ff[wb] <= 1'b1; // [R11]
      end
    end
  end

  // Free space and stored packet ends
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        free_ff[c] <= '0;
        eop_ff[c] <= '0;
      end
    end else begin
      if (rd_blk_done) begin
        free_ff[fch_ff] <= free_ff[fch_ff] + CNT_W'(1); // [R13]
      end
      if (eop_dec) begin
        eop_ff[fch_ff] <= eop_ff[fch_ff] - CNT_W'(1); // [R14]
      end
      if (wr_rep) begin
        free_ff[wch_ff] <= free_ff[wch_ff] - CNT_W'(rep_blk) + CNT_W'(rd_blk_done && fch_ff == wch_ff); // [R17]
        eop_ff[wch_ff] <= eop_ff[wch_ff] + rep_eop - CNT_W'(eop_dec && fch_ff == wch_ff);
      end
      if (ch_prov) begin
        free_ff[ich_ff] <= icfg_ff.chain_len; // [R21]
        eop_ff[ich_ff] <= '0;
      end
    end
  end
endmodule // tx_framer_buffer_block

// [sim/tx_fbb_sva.sv]
// Port checker of the framer
// Assumes binding into the framer
`timescale 1ns/1ps
module tx_fbb_sva
  import tx_hdlc_pkg::*;
#(
  parameter int CW = 7
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic asg_req_i,
  input wire logic null_cycle_i,
  input wire logic asg_busy_o,
  input wire logic asg_valid_o,
  input wire logic ind_busy_o,
  input wire logic ind_done_o,
  input wire logic dma_req_o,
  input wire logic dma_gnt_i,
  input wire logic dma_exp_o,
  input wire logic [CW-1:0] dma_chan_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // Take, bit steps, answer
  sequence s_take;
    asg_req_i && !asg_busy_o;
  endsequence
  sequence s_bits;
    (asg_busy_o && !asg_valid_o) [*8] ##1 (asg_busy_o && !asg_valid_o);
  endsequence
  sequence s_give;
    (!asg_busy_o && asg_valid_o) ##1 !asg_valid_o;
  endsequence
  a_byte_latency: assert property (s_take |=> s_bits ##1 s_give)
    else $error("byte late");
  a_byte_demand: assert property (asg_valid_o |-> $past(asg_busy_o))
    else $error("byte unasked");
  a_valid_single: assert property (asg_valid_o |=> !asg_valid_o)
    else $error("valid too long");
  a_ind_wait: assert property (ind_busy_o && !null_cycle_i |=> ind_busy_o && !ind_done_o)
    else $error("op off null");
  a_ind_exec: assert property (ind_busy_o && null_cycle_i |=> !ind_busy_o && ind_done_o)
    else $error("null missed");
  a_done_null: assert property (ind_done_o |-> $past(null_cycle_i) && $past(ind_busy_o))
    else $error("stray done");
  a_dma_hold: assert property (dma_req_o && !dma_gnt_i |=> dma_req_o && $stable(dma_chan_o) && $stable(dma_exp_o))
    else $error("req changed");
  a_dma_drop: assert property (dma_req_o && dma_gnt_i |=> !dma_req_o)
    else $error("req held");
endmodule // tx_fbb_sva
bind tx_framer_buffer_block tx_fbb_sva #(.CW(CW)) i_sva (.*);

// [sim/tx_dma_model.sv]
// DMA side model of the framer
// Assumes bytes come from seed_i and channel
`timescale 1ns/1ps
module tx_dma_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [6:0] chan_i,
  input wire logic [7:0] seed_i,
  input wire logic [3:0] len_i,
  input wire logic [3:0] dly_i,
  output logic gnt_o,
  output logic valid_o,
  output logic [7:0] byte_o,
  output logic eop_o,
  output logic last_o
);
  logic [6:0] c;
  initial begin
    gnt_o = 1'b0;
    valid_o = 1'b0;
    byte_o = 8'h00;
    eop_o = 1'b0;
    last_o = 1'b0;
    forever begin
      @(posedge ref_clk_i);
      // Requests served in order, one list each
      if (!rst_i && req_i) begin
        c = chan_i;
        repeat (dly_i) @(posedge ref_clk_i);
        gnt_o <= 1'b1;
        @(posedge ref_clk_i);
        gnt_o <= 1'b0;
        // Whole packet, two bytes or more
        for (int i = 0; i < len_i; i++) begin
          valid_o <= 1'b1;
          byte_o <= {1'b0, seed_i[6:0] ^ c} + 8'(i);
          eop_o <= (i == len_i - 1);
          last_o <= (i == len_i - 1);
          @(posedge ref_clk_i);
        end
        valid_o <= 1'b0;
        eop_o <= 1'b0;
        last_o <= 1'b0;
        byte_o <= ~byte_o;
      end
    end
  end
endmodule // tx_dma_model

// [sim/tx_framer_buffer_block_tb.sv]
// Bench of the framer
// Assumes the DMA model and bound checker
`timescale 1ns/1ps
module tx_framer_buffer_block_tb;
  import tx_hdlc_pkg::*;
  logic ref_clk_i, rst_i, asg_req_i, null_cycle_i, asg_busy_o, asg_valid_o, underrun_o;
  logic dma_req_o, dma_exp_o, dma_gnt_i, dma_valid_i, dma_eop_i, dma_last_i, ind_busy_o, ind_done_o;
  logic ind_chan_req_i, ind_chan_wr_i, ind_blk_req_i, ind_blk_wr_i;
  logic [6:0] asg_chan_i, underrun_chan_o, dma_chan_o, ind_chan_i;
  logic [7:0] asg_byte_o, dma_byte_i, seed, by, sh, w;
  logic [3:0] dma_max_o, len, dly;
  logic [8:0] ind_blk_i, ind_next_i, ind_next_o, rb, rn;
  logic [15:0] fc;
  chan_cfg_s ind_cfg_i, ind_cfg_o, cf5, cf6;
  logic q[$];
  logic f[$];
  int fail_count, num_checks, cyc, urun;
  tx_framer_buffer_block i_dut (.*);
  tx_dma_model i_dma (.ref_clk_i, .rst_i, .req_i(dma_req_o), .chan_i(dma_chan_o), .seed_i(seed),
    .len_i(len), .dly_i(dly), .gnt_o(dma_gnt_i), .valid_o(dma_valid_i), .byte_o(dma_byte_i),
    .eop_o(dma_eop_i), .last_o(dma_last_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // Cycles, under-runs, hang guard
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (underrun_o === 1'b1) urun <= urun + 1;
    if (cyc == 40000) begin
      fail_count++;
      print_verdict();
    end
  end
  // Null cycle every fourth cycle
  always @(negedge ref_clk_i) null_cycle_i <= (cyc % 4 == 3);
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic ind(input logic ch, input logic wr, input logic [8:0] b, input logic [8:0] n,
                     input logic [6:0] c, input chan_cfg_s cf);
    @(negedge ref_clk_i);
    ind_chan_req_i = ch;
    ind_blk_req_i = !ch;
    ind_chan_wr_i = wr;
    ind_blk_wr_i = wr;
    ind_blk_i = b;
    ind_next_i = n;
    ind_chan_i = c;
    ind_cfg_i = cf;
    @(negedge ref_clk_i);
    ind_chan_req_i = 1'b0;
    ind_blk_req_i = 1'b0;
    for (int k = 0; k < 20 && ind_done_o !== 1'b1; k++) @(negedge ref_clk_i);
    chk("ind_done", ind_done_o, 1'b1);
  endtask
  task automatic get(input logic [6:0] c, output logic [7:0] b);
    @(negedge ref_clk_i);
    asg_req_i = 1'b1;
    asg_chan_i = c;
    @(negedge ref_clk_i);
    asg_req_i = 1'b0;
    for (int k = 0; k < 12 && asg_valid_o !== 1'b1; k++) @(negedge ref_clk_i);
    b = asg_byte_o;
  endtask
  function automatic logic [7:0] exp_byte(input logic [6:0] c, input int i);
    return {1'b0, seed[6:0] ^ c} + 8'(i);
  endfunction
  function automatic logic [15:0] fcs16(input logic [6:0] c, input int n);
    logic [15:0] r;
    logic [7:0] d;
    r = 16'hffff;
    for (int i = 0; i < n; i++) begin
      d = exp_byte(c, i);
      for (int b = 0; b < 8; b++) r = (r[0] ^ d[b]) ? (r >> 1) ^ 16'h8408 : r >> 1;
    end
    return ~r;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    int st, ones, nf;
    logic [8:0] bl[5];
    logic [8:0] nx[5];
    bl = '{9'h001, 9'h003, 9'h0c8, 9'h00a, 9'h00b};
    nx = '{9'h003, 9'h0c8, 9'h001, 9'h00b, 9'h00a};
    {asg_req_i, ind_chan_req_i, ind_chan_wr_i, ind_blk_req_i, ind_blk_wr_i, null_cycle_i} = '0;
    {asg_chan_i, ind_chan_i, ind_blk_i, ind_next_i, ind_cfg_i} = '0;
    {fail_count, num_checks, cyc, urun, st, nf} = '0;
    rst_i = 1'b1;
    void'($urandom(32'h85f28bda));
    seed = 8'($urandom);
    len = 4'(2 + $urandom % 7);
    dly = 4'($urandom % 8);
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    chk("quiet", {asg_valid_o, dma_req_o, ind_busy_o, underrun_o}, 4'h0);
    $display("test reset done");
    rb = 9'(300 + $urandom % 200);
    rn = 9'($urandom);
    for (int i = 0; i < 5; i++) ind(1'b0, 1'b1, bl[i], nx[i], 7'h00, '0);
    ind(1'b0, 1'b1, rb, rn, 7'h00, '0);
    for (int i = 0; i < 5; i++) begin
      ind(1'b0, 1'b0, bl[i], 9'h000, 7'h00, '0);
      chk("next_ptr", ind_next_o, nx[i]);
    end
    ind(1'b0, 1'b0, rb, 9'h000, 7'h00, '0);
    chk("next_rand", ind_next_o, rn);
    $display("test chain done");
    get(7'(20 + $urandom % 100), by);
    chk("idle_fill", by, 8'hff);
    cf5 = '{1'b1, 1'b0, 1'b1, 1'b0, 3'h0, 10'h001, 10'h000, 4'h3, 9'h003, 10'h003};
    ind(1'b1, 1'b1, 9'h000, 9'h000, 7'h05, cf5);
    for (int k = 0; k < 40 && dma_req_o !== 1'b1; k++) @(negedge ref_clk_i);
    chk("dma_chan", dma_chan_o, 7'h05);
    chk("dma_exp", dma_exp_o, 1'b0);
    chk("dma_max", dma_max_o, cf5.burst);
    ind(1'b1, 1'b0, 9'h000, 9'h000, 7'h05, '0);
    chk("cfg_back", ind_cfg_o, cf5);
    $display("test provision done");
    get(7'h05, by);
    chk("open_flag", by, 8'h7e);
    for (int j = 0; j < 300 && nf == 0; j++) begin
      get(7'h05, by);
      for (int b = 0; b < 8; b++) begin
        sh = {by[b], sh[7:1]};
        q.push_back(by[b]);
        if (sh == 8'h7e) begin
          if (st != 0 && q.size() > 8) begin
            ones = 0;
            f = {};
            for (int k = 0; k < q.size() - 8; k++) begin
              if (ones == 5 && !q[k]) ones = 0;
              else begin
                f.push_back(q[k]);
                ones = q[k] ? ones + 1 : 0;
              end
            end
            nf = 1;
          end
          q = {};
          st = 1;
        end
      end
    end
    chk("frame_bits", f.size(), (len + 2) * 8);
    fc = fcs16(7'h05, len);
    for (int i = 0; i < len + 2 && f.size() == (len + 2) * 8; i++) begin
      for (int b = 0; b < 8; b++) w[b] = f[i * 8 + b];
      chk("frame_byte", w, i < len ? exp_byte(7'h05, i) : (i == len ? fc[7:0] : fc[15:8]));
    end
    $display("test frame done");
    cf6 = '{1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 10'h001, 10'h000, 4'h2, 9'h00a, 10'h002};
    ind(1'b1, 1'b1, 9'h000, 9'h000, 7'h06, cf6);
    by = 8'hff;
    for (int j = 0; j < 100 && by === 8'hff; j++) get(7'h06, by);
    for (int i = 0; i < len; i++) begin
      if (i > 0) get(7'h06, by);
      chk("transp_byte", by, exp_byte(7'h06, i));
    end
    chk("underruns", urun, 0);
    $display("test transparent done");
    print_verdict();
  end
endmodule // tx_framer_buffer_block_tb
